// ---- rtl/oscillator_switch_control.sv ----
// Oscillator selection and clock-switch control with four byte registers.
// Assumes a plain register port and source ready inputs synchronous to ref_clk.
`timescale 1ns/100ps
`default_nettype none
module oscillator_switch_control (
    input  wire logic       ref_clk,
    input  wire logic       resetn,
    input  wire logic [1:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output var  logic [7:0] reg_rdata,
    input  wire logic [2:0] reset_source_cfg,
    input  wire logic       switch_enable_cfg,
    input  wire logic       switch_irq_enable,
    input  wire logic [5:0] osc_enable,
    input  wire logic [5:0] osc_ready,
    input  wire logic       pll_enable,
    input  wire logic       pll_locked,
    output var  logic [2:0] active_source,
    output var  logic [3:0] active_divider,
    output var  logic       secondary_power_mode,
    output var  logic       switch_irq_flag,
    output var  logic       switch_irq_req
);
    logic                 rst_meta;
    logic                 rst_n;
    logic [1:0]           instr_cnt;
    logic [1:0]           next_instr_cnt;
    logic                 instr_tick;
    logic [osc_switch_pkg::NUM_READY-1:0] rdy_en;
    logic [osc_switch_pkg::NUM_READY-1:0] rdy_in;
    logic [osc_switch_pkg::NUM_READY-1:0] rdy_q;
    osc_switch_pkg::sw_state_e state;
    osc_switch_pkg::sw_state_e next_state;
    logic [2:0]           requested_source;
    logic [3:0]           requested_divider;
    logic [2:0]           next_requested_source;
    logic [3:0]           next_requested_divider;
    logic [2:0]           next_active_source;
    logic [3:0]           next_active_divider;
    logic                 switch_hold;
    logic                 next_switch_hold;
    logic                 next_secondary_power_mode;
    logic                 new_source_ready;
    logic                 next_new_source_ready;
    logic                 next_switch_irq_flag;
    logic                 next_switch_irq_req;
    logic [7:0]           next_reg_rdata;
    logic                 pending;
    logic                 switch_done;
    logic                 sel_ready;
    logic                 src_reserved;
    logic                 div_reserved;
    logic [2:0]           boot_source;
    logic [3:0]           boot_divider;

    // Reset release through two flops
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    // Instruction cycle divider
    always_comb begin
        instr_tick     = (instr_cnt == osc_switch_pkg::INSTR_LAST);
        next_instr_cnt = instr_tick ? 2'h0 : instr_cnt + 2'h1;
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            instr_cnt <= 2'h0;
        end else begin
            instr_cnt <= next_instr_cnt;
        end
    end

    // Ready qualifiers; PLL needs the external source ready too
    always_comb begin
        rdy_en = {pll_enable & osc_enable[5] & osc_ready[5], osc_enable};
        rdy_in = {pll_locked, osc_ready};
    end

    genvar gi;
    generate
        for (gi = 0; gi < osc_switch_pkg::NUM_READY; gi++) begin : g_rdy
            source_ready_flag u_flag (
                .ref_clk (ref_clk),
                .rst_n   (rst_n),
                .enable  (rdy_en[gi]),
                .ready   (rdy_in[gi]),
                .flag    (rdy_q[gi])
            );
        end
    endgenerate

    // Power-on defaults from the reset-source setting
    always_comb begin
        boot_source  = reset_source_cfg;
        boot_divider = osc_switch_pkg::DIV_1;
        case (reset_source_cfg)
            osc_switch_pkg::SRC_FAST: begin
                boot_divider = osc_switch_pkg::DIV_4;
            end
            osc_switch_pkg::SRC_RSV_ZERO: begin
                boot_source = osc_switch_pkg::SRC_FAST;
            end
            osc_switch_pkg::SRC_RSV_HI,
            osc_switch_pkg::SRC_RSV_LO: begin
                boot_source  = osc_switch_pkg::SRC_FAST;
                boot_divider = osc_switch_pkg::DIV_4;
            end
            default: begin
                boot_divider = osc_switch_pkg::DIV_1;
            end
        endcase
    end

    // Code decode and readiness of the requested source
    always_comb begin
        src_reserved = (reg_wdata[6:4] == osc_switch_pkg::SRC_RSV_HI)
                     | (reg_wdata[6:4] == osc_switch_pkg::SRC_RSV_LO)
                     | (reg_wdata[6:4] == osc_switch_pkg::SRC_RSV_ZERO);
        div_reserved = (reg_wdata[3:0] > osc_switch_pkg::DIV_MAX);
        pending      = {requested_source, requested_divider}
                    != {active_source, active_divider};
        switch_done  = !pending;
        case (requested_source)
            osc_switch_pkg::SRC_EXT:     sel_ready = rdy_q[5];
            osc_switch_pkg::SRC_FAST:    sel_ready = rdy_q[4];
            osc_switch_pkg::SRC_SLOW:    sel_ready = rdy_q[2];
            osc_switch_pkg::SRC_SEC:     sel_ready = rdy_q[1];
            osc_switch_pkg::SRC_EXT_PLL: sel_ready = rdy_q[osc_switch_pkg::PLL_IDX];
            default:                     sel_ready = 1'b0;
        endcase
    end

    // Switch sequencer and register writes
    always_comb begin
        next_state                = state;
        next_requested_source     = requested_source;
        next_requested_divider    = requested_divider;
        next_active_source        = active_source;
        next_active_divider       = active_divider;
        next_switch_hold          = switch_hold;
        next_secondary_power_mode = secondary_power_mode;
        next_new_source_ready     = new_source_ready;
        next_switch_irq_flag      = 1'b0;
        next_switch_irq_req       = 1'b0;
        case (state)
            osc_switch_pkg::ST_BOOT: begin
                next_requested_source  = boot_source;
                next_requested_divider = boot_divider;
                next_active_source     = boot_source;
                next_active_divider    = boot_divider;
                next_state             = osc_switch_pkg::ST_IDLE;
            end
            osc_switch_pkg::ST_IDLE: begin
                if (pending) begin
                    next_state = osc_switch_pkg::ST_WAIT;
                end
            end
            osc_switch_pkg::ST_WAIT: begin
                if (!pending) begin
                    next_state = osc_switch_pkg::ST_IDLE;
                end else if (sel_ready && instr_tick) begin
                    next_new_source_ready = 1'b1;
                    next_switch_irq_flag  = 1'b1;
                    next_switch_irq_req   = switch_irq_enable;
                    next_state            = osc_switch_pkg::ST_READY;
                end
            end
            osc_switch_pkg::ST_READY: begin
                if (!pending) begin
                    next_new_source_ready = 1'b0;
                    next_state            = osc_switch_pkg::ST_IDLE;
                end else if (!sel_ready) begin
                    next_new_source_ready = 1'b0;
                    next_state            = osc_switch_pkg::ST_WAIT;
                end else if (!switch_hold && instr_tick) begin
                    next_active_source    = requested_source;
                    next_active_divider   = requested_divider;
                    next_new_source_ready = 1'b0;
                    next_state            = osc_switch_pkg::ST_IDLE;
                end
            end
            default: begin
                next_state = osc_switch_pkg::ST_BOOT;
            end
        endcase
        if (reg_wr && state != osc_switch_pkg::ST_BOOT) begin
            if (reg_addr == osc_switch_pkg::REQ_CTRL_OFS && switch_enable_cfg
                && !src_reserved && !div_reserved) begin
                next_requested_source  = reg_wdata[6:4];
                next_requested_divider = reg_wdata[3:0];
            end
            if (reg_addr == osc_switch_pkg::SW_CTRL_OFS) begin
                next_switch_hold          = reg_wdata[osc_switch_pkg::HOLD_BIT];
                next_secondary_power_mode = reg_wdata[osc_switch_pkg::PWR_BIT];
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state                <= osc_switch_pkg::ST_BOOT;
            requested_source     <= osc_switch_pkg::SRC_FAST;
            requested_divider    <= osc_switch_pkg::DIV_4;
            active_source        <= osc_switch_pkg::SRC_FAST;
            active_divider       <= osc_switch_pkg::DIV_4;
            switch_hold          <= osc_switch_pkg::HOLD_RST;
            secondary_power_mode <= osc_switch_pkg::PWR_RST;
            new_source_ready     <= 1'b0;
            switch_irq_flag      <= 1'b0;
            switch_irq_req       <= 1'b0;
        end else begin
            state                <= next_state;
            requested_source     <= next_requested_source;
            requested_divider    <= next_requested_divider;
            active_source        <= next_active_source;
            active_divider       <= next_active_divider;
            switch_hold          <= next_switch_hold;
            secondary_power_mode <= next_secondary_power_mode;
            new_source_ready     <= next_new_source_ready;
            switch_irq_flag      <= next_switch_irq_flag;
            switch_irq_req       <= next_switch_irq_req;
        end
    end

    // Read mux; data stand only in the cycle after the strobe
    always_comb begin
        next_reg_rdata = 8'h00;
        if (reg_rd) begin
            case (reg_addr)
                osc_switch_pkg::REQ_CTRL_OFS: begin
                    next_reg_rdata = {1'b0, requested_source, requested_divider};
                end
                osc_switch_pkg::ACT_STAT_OFS: begin
                    next_reg_rdata = {1'b0, active_source, active_divider};
                end
                osc_switch_pkg::SW_CTRL_OFS: begin
                    next_reg_rdata = {switch_hold, secondary_power_mode, 1'b0,
                                      switch_done, new_source_ready, 3'h0};
                end
                osc_switch_pkg::RDY_STAT_OFS: begin
                    next_reg_rdata = {rdy_q[5:0], 1'b0,
                                      rdy_q[osc_switch_pkg::PLL_IDX]};
                end
                default: begin
                    next_reg_rdata = 8'h00;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 8'h00;
        end else begin
            reg_rdata <= next_reg_rdata;
        end
    end

    // Checks on the switch sequence and register port
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    AST_RESERVED_WRITE: assert property (
        reg_wr && reg_addr == osc_switch_pkg::REQ_CTRL_OFS && src_reserved
        && state != osc_switch_pkg::ST_BOOT
        |=> $stable({requested_source, requested_divider}))
        else $error("reserved source write changed the request");

    AST_LOCKED_REQUEST: assert property (
        !switch_enable_cfg && state != osc_switch_pkg::ST_BOOT
        |=> $stable({requested_source, requested_divider}))
        else $error("request changed while switching is disabled");

    AST_BOOT_DEFAULT: assert property (
        state == osc_switch_pkg::ST_BOOT
        && reset_source_cfg == osc_switch_pkg::SRC_RSV_ZERO
        |=> active_source == osc_switch_pkg::SRC_FAST
        && active_divider == osc_switch_pkg::DIV_1)
        else $error("wrong default for reset source 000");

    AST_HOLD_KEEPS_OLD: assert property (
        state == osc_switch_pkg::ST_READY && switch_hold
        |=> $stable({active_source, active_divider}))
        else $error("switch completed while held");

    AST_SWITCH_TAKES: assert property (
        state == osc_switch_pkg::ST_READY && !switch_hold && instr_tick
        && pending && sel_ready && !reg_wr
        |=> active_source == $past(requested_source) && switch_done
        && !new_source_ready)
        else $error("switch did not complete on the instruction tick");

    AST_NEWRDY_PENDING: assert property (
        new_source_ready |-> pending || $past(reg_wr))
        else $error("new-ready set with no switch in progress");

    AST_IRQ_WITH_NEWRDY: assert property (
        $rose(new_source_ready) |-> switch_irq_flag
        && switch_irq_req == $past(switch_irq_enable))
        else $error("switch interrupt flag not coincident with new-ready");

    AST_NEWRDY_BOUNDED: assert property (
        state == osc_switch_pkg::ST_WAIT && sel_ready && !switch_hold
        && !reg_wr ##1 !reg_wr[*4] |-> state != osc_switch_pkg::ST_WAIT)
        else $error("new-ready later than one instruction cycle");

    AST_RDATA_ONE_CYCLE: assert property (
        !reg_rd |=> reg_rdata == 8'h00)
        else $error("read data stood outside the read cycle");

    AST_PLL_READ: assert property (
        reg_rd && reg_addr == osc_switch_pkg::RDY_STAT_OFS
        |=> reg_rdata[0] == $past(rdy_q[osc_switch_pkg::PLL_IDX])
        && reg_rdata[1] == 1'b0)
        else $error("PLL ready bit misreported");

    AST_STATUS_READ: assert property (
        reg_rd && reg_addr == osc_switch_pkg::SW_CTRL_OFS
        |=> reg_rdata[osc_switch_pkg::DONE_BIT] == !$past(pending)
        && reg_rdata[osc_switch_pkg::NEWRDY_BIT] == $past(new_source_ready))
        else $error("switch status bits misreported");

    COV_SWITCH_DONE: cover property (
        state == osc_switch_pkg::ST_READY ##1 state == osc_switch_pkg::ST_IDLE
        && switch_done);
    COV_HELD: cover property (
        state == osc_switch_pkg::ST_READY && switch_hold [*3]);
    COV_ABANDON: cover property (
        state == osc_switch_pkg::ST_READY ##1 !pending && !new_source_ready);
    COV_MASKED_IRQ: cover property (
        switch_irq_flag && !switch_irq_req);
    COV_REFUSED_WRITE: cover property (
        reg_wr && reg_addr == osc_switch_pkg::REQ_CTRL_OFS
        && (src_reserved || div_reserved));
endmodule
`default_nettype wire

// ---- rtl/osc_switch_pkg.sv ----
// Constants for the oscillator selection and clock-switch control block.
// Assumes an 8-bit register port and a 125 MHz single clock.
// Notes on behaviour
// - Request register holds source in bits 6-4, divider in 3-0; bit 7 zero.
// - After power-on the requested source comes from the reset-source setting.
// - A write carrying a reserved source code changes neither request field.
// - With switching disabled by configuration the request register is read-only.
// - Reset defaults: 110, 001 and 011 give fast internal 4:1, 000 gives 110 1:1, others 1:1.
// - Active status register shows active source in 6-4 and divider in 3-0.
// - Active fields after power-on show the settings in effect at start.
// - Hold set and new source ready: switch waits, interrupt flag raised.
// - Hold clear: switch happens once the new source reports ready.
// - Hold bit is read/write and resets to zero.
// - Bit 6 of switch control picks secondary oscillator power, resets low.
// - Switch-done reads one when active equals requested, else zero.
// - New-ready reads one only while switching and the new source is ready.
// - Without hold, new-ready rises within one instruction cycle then clears.
// - Ready status bits 7 to 2 show each oscillator enabled and ready.
// - Bit 0 shows the PLL enabled, fed by a ready source and locked.
// - Unimplemented bits read as zero and ignore writes.
// - Source and divider encodings; reserved codes listed separately.
// - At the switch, active fields update, done sets, new-ready clears.
// - Switch interrupt flag sets with new-ready; request only when enabled.
package osc_switch_pkg;
    // Register offsets
    localparam logic [1:0] REQ_CTRL_OFS   = 2'h0;
    localparam logic [1:0] ACT_STAT_OFS   = 2'h1;
    localparam logic [1:0] SW_CTRL_OFS    = 2'h2;
    localparam logic [1:0] RDY_STAT_OFS   = 2'h3;
    // Field positions
    localparam int SRC_LSB     = 4;
    localparam int HOLD_BIT    = 7;
    localparam int PWR_BIT     = 6;
    localparam int DONE_BIT    = 4;
    localparam int NEWRDY_BIT  = 3;
    // Source codes
    localparam logic [2:0] SRC_EXT      = 3'h7;
    localparam logic [2:0] SRC_FAST     = 3'h6;
    localparam logic [2:0] SRC_SLOW     = 3'h5;
    localparam logic [2:0] SRC_SEC      = 3'h4;
    localparam logic [2:0] SRC_EXT_PLL  = 3'h2;
    localparam logic [2:0] SRC_RSV_HI   = 3'h3;
    localparam logic [2:0] SRC_RSV_LO   = 3'h1;
    localparam logic [2:0] SRC_RSV_ZERO = 3'h0;
    // Divider codes
    localparam logic [3:0] DIV_1        = 4'h0;
    localparam logic [3:0] DIV_4        = 4'h2;
    localparam logic [3:0] DIV_MAX      = 4'h9;
    // Reset values of software-owned bits
    localparam logic       HOLD_RST     = 1'b0;
    localparam logic       PWR_RST      = 1'b0;
    // Ready vector layout: oscillators 5..0 then PLL
    localparam int NUM_READY   = 7;
    localparam int PLL_IDX     = 6;
    // Instruction cycle as a count of system clocks
    localparam int INSTR_CLKS  = 4;
    localparam logic [1:0] INSTR_LAST = 2'(INSTR_CLKS - 1);
    typedef enum logic [1:0] {
        ST_BOOT  = 2'b00,
        ST_IDLE  = 2'b01,
        ST_WAIT  = 2'b10,
        ST_READY = 2'b11
    } sw_state_e;
endpackage

// ---- rtl/source_ready_flag.sv ----
// One ready flag: set while a source is both enabled and reporting ready.
// Assumes inputs synchronous to ref_clk.
`timescale 1ns/100ps
`default_nettype none
module source_ready_flag (
    input  wire logic ref_clk,
    input  wire logic rst_n,
    input  wire logic enable,
    input  wire logic ready,
    output var  logic flag
);
    logic next_flag;

    // Qualify ready with enable
    always_comb begin
        next_flag = enable & ready;
    end

    // Register the flag
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            flag <= 1'b0;
        end else begin
            flag <= next_flag;
        end
    end
endmodule
`default_nettype wire

// ---- tb/osc_source_model.sv ----
// Behavioural oscillator sources and PLL lock detector.
// Assumes enables and a start-up count driven by the bench.
`timescale 1ns/100ps
`default_nettype none
module osc_source_model (
    input  wire logic       ref_clk,
    input  wire logic [5:0] osc_enable,
    input  wire logic       pll_enable,
    input  wire logic [7:0] startup,
    output var  logic [5:0] osc_ready,
    output var  logic       pll_locked
);
    logic [6:0] en;
    logic [7:0] cnt [7] = '{default: 8'h00};
    assign en = {pll_enable, osc_enable};
    // Start-up count per source; restarts when the source is dropped
    always_ff @(posedge ref_clk) begin
        for (int i = 0; i < 7; i++) begin
            if (!en[i]) begin
                cnt[i] <= 8'h00;
            end else if (cnt[i] != 8'hFF) begin
                cnt[i] <= cnt[i] + 8'h01;
            end
        end
    end
    // Ready only once settled; a dropped source is not ready at once
    always_comb begin
        for (int i = 0; i < 6; i++) begin
            osc_ready[i] = en[i] && (cnt[i] >= startup);
        end
        pll_locked = en[6] && (cnt[6] >= startup);
    end
endmodule
`default_nettype wire

// ---- tb/oscillator_switch_control_bench.sv ----
// Self-checking bench for the oscillator switch control block.
// Assumes the design files and osc_source_model are compiled first.
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin err_count++; \
    $display("MISMATCH %s exp %h got %h", n, e, g); end end
module oscillator_switch_control_bench;
    typedef struct {logic [7:0] w; logic [7:0] e;} row_s;
    logic       ref_clk = 1'b0;
    logic       resetn = 1'b0;
    logic [1:0] reg_addr = 2'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic       reg_wr = 1'b0;
    logic       reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    logic [2:0] reset_source_cfg = 3'h6;
    logic       switch_enable_cfg = 1'b1;
    logic       switch_irq_enable = 1'b1;
    logic [5:0] osc_enable = 6'h10;
    logic [5:0] osc_ready;
    logic       pll_enable = 1'b0;
    logic       pll_locked;
    logic [7:0] startup = 8'h03;
    logic [2:0] active_source;
    logic [3:0] active_divider;
    logic       secondary_power_mode;
    logic       switch_irq_flag;
    logic       switch_irq_req;
    logic [7:0] rd_val;
    int         err_count = 0;
    int         checks = 0;
    int         n;
    row_s       rows [6] = '{'{8'h30, 8'h62}, '{8'h10, 8'h62}, '{8'h05, 8'h62},
                             '{8'h6A, 8'h62}, '{8'hE9, 8'h69}, '{8'h60, 8'h60}};

    always #4 ref_clk = ~ref_clk;

    oscillator_switch_control u_oscillator_switch_control (
        .ref_clk(ref_clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .reset_source_cfg(reset_source_cfg), .switch_enable_cfg(switch_enable_cfg),
        .switch_irq_enable(switch_irq_enable), .osc_enable(osc_enable),
        .osc_ready(osc_ready), .pll_enable(pll_enable), .pll_locked(pll_locked),
        .active_source(active_source), .active_divider(active_divider),
        .secondary_power_mode(secondary_power_mode), .switch_irq_flag(switch_irq_flag),
        .switch_irq_req(switch_irq_req));
    osc_source_model u_osc_source_model (
        .ref_clk(ref_clk), .osc_enable(osc_enable), .pll_enable(pll_enable),
        .startup(startup), .osc_ready(osc_ready), .pll_locked(pll_locked));

    task automatic stop_test;
        $display("Checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // Expected request and active value after power-on per reset-source code
    function automatic logic [7:0] dflt(input logic [2:0] c);
        case (c)
            3'h0: return 8'h60;
            3'h1, 3'h3, 3'h6: return 8'h62;
            default: return {1'b0, c, 4'h0};
        endcase
    endfunction

    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [1:0] a);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 rd_val = reg_rdata;
    endtask

    task automatic do_reset(input logic [2:0] cfg, input logic en);
        @(posedge ref_clk);
        resetn <= 1'b0;
        reset_source_cfg <= cfg;
        switch_enable_cfg <= en;
        repeat (3) @(posedge ref_clk);
        resetn <= 1'b1;
        repeat (4) @(posedge ref_clk);
    endtask

    // Waits for the new-source pulse, then times the switch when not held
    task automatic wait_switch(input logic [7:0] req, input logic held);
        int i;
        i = 0;
        #1;
        while (switch_irq_flag !== 1'b1) begin
            @(posedge ref_clk);
            #1;
            i++;
            if (i > 200) begin
                err_count++;
                $display("MISMATCH irq_flag exp 1 got 0");
                stop_test();
            end
        end
        `CHK("irq_req", switch_irq_enable, switch_irq_req)
        if (!held) begin
            i = 0;
            while ({1'b0, active_source, active_divider} !== req && i < 20) begin
                @(posedge ref_clk);
                #1;
                i++;
            end
            `CHK("switch_lat", 4, i)
        end
    endtask

    initial begin
        do_reset(3'h6, 1'b1);
        // Request rows: refused codes keep the old value, valid ones switch
        foreach (rows[k]) begin
            wr(2'h0, rows[k].w);
            rd(2'h0);
            `CHK("request", rows[k].e, rd_val)
            repeat (16) @(posedge ref_clk);
            rd(2'h1);
            `CHK("active", rows[k].e, rd_val)
            rd(2'h2);
            `CHK("sw_ctrl", 8'h10, rd_val)
        end
        // Power-on defaults for every reset-source code
        for (int c = 0; c < 8; c++) begin
            do_reset(3'(c), 1'b1);
            rd(2'h0);
            `CHK("req_dflt", dflt(3'(c)), rd_val)
            rd(2'h1);
            `CHK("act_dflt", dflt(3'(c)), rd_val)
            rd(2'h2);
            `CHK("ctl_dflt", 8'h10, rd_val)
        end
        do_reset(3'h6, 1'b1);
        // Switch with hold clear, interrupt enabled then masked
        wr(2'h0, 8'h60);
        wait_switch(8'h60, 1'b0);
        @(posedge ref_clk);
        switch_irq_enable <= 1'b0;
        wr(2'h0, 8'h61);
        wait_switch(8'h61, 1'b0);
        // Request equal to the active setting raises nothing
        wr(2'h0, 8'h61);
        n = 0;
        repeat (12) begin
            @(posedge ref_clk);
            #1;
            if (switch_irq_flag !== 1'b0) n++;
        end
        `CHK("idle_flags", 0, n)
        // Held switch, abandoned, then requested again and released
        @(posedge ref_clk);
        switch_irq_enable <= 1'b1;
        wr(2'h2, 8'hC0);
        #1;
        `CHK("pwr_mode", 1'b1, secondary_power_mode)
        rd(2'h2);
        `CHK("hold_set", 8'hD0, rd_val)
        wr(2'h0, 8'h63);
        wait_switch(8'h63, 1'b1);
        repeat (12) @(posedge ref_clk);
        rd(2'h2);
        `CHK("held_ctl", 8'hC8, rd_val)
        rd(2'h1);
        `CHK("held_act", 8'h61, rd_val)
        wr(2'h0, 8'h61);
        rd(2'h2);
        `CHK("abandon", 8'hD0, rd_val)
        wr(2'h0, 8'h63);
        wait_switch(8'h63, 1'b1);
        wr(2'h2, 8'h40);
        repeat (12) @(posedge ref_clk);
        rd(2'h1);
        `CHK("released", 8'h63, rd_val)
        // Slow source disabled: switch stalls until it starts up
        startup <= 8'h28;
        wr(2'h0, 8'h50);
        repeat (20) @(posedge ref_clk);
        rd(2'h2);
        `CHK("stalled", 8'h40, rd_val)
        @(posedge ref_clk);
        osc_enable <= 6'h14;
        rd(2'h3);
        `CHK("not_ready", 8'h40, rd_val)
        wait_switch(8'h50, 1'b0);
        // Ready flags and PLL usability
        @(posedge ref_clk);
        osc_enable <= 6'h34;
        pll_enable <= 1'b1;
        repeat (60) @(posedge ref_clk);
        rd(2'h3);
        `CHK("rdy_pll", 8'hD1, rd_val)
        @(posedge ref_clk);
        osc_enable <= 6'h14;
        repeat (3) @(posedge ref_clk);
        rd(2'h3);
        `CHK("pll_no_src", 8'h50, rd_val)
        @(posedge ref_clk);
        osc_enable <= 6'h3F;
        repeat (60) @(posedge ref_clk);
        rd(2'h3);
        `CHK("rdy_all", 8'hFD, rd_val)
        // Status registers ignore writes
        wr(2'h1, 8'hFF);
        wr(2'h3, 8'h00);
        rd(2'h1);
        `CHK("ro_act", 8'h50, rd_val)
        // Request register frozen when switching is disabled
        do_reset(3'h5, 1'b0);
        wr(2'h0, 8'h61);
        rd(2'h0);
        `CHK("locked", 8'h50, rd_val)
        stop_test();
    end
endmodule
`default_nettype wire
